// [design/itdt_pkg.sv]
package itdt_pkg;

  // Source count: five enable registers of eight bits each.
  localparam int unsigned NUM_SRC      = 40;
  localparam int unsigned NUM_RECORDS  = 24;
  localparam int unsigned REG_AW       = 20;

  // Register map on the plain register port.
  localparam logic [19:0] BASE_PAGE_ADDR  = 20'hf02e0;
  localparam logic [19:0] ENABLE0_ADDR    = 20'hf02e8;
  localparam logic [7:0]  BASE_PAGE_RESET = 8'hfd;
  localparam logic [7:0]  ENABLE_RESET    = 8'h00;

  // Cleared bits mark positions with a reserved source; these never start a transfer.
  localparam logic [39:0] SRC_VALID_MASK = 40'hf8_ff_ff_bf_7f;

  // Layout of one control-data record: size and word step in bytes, word positions as indices from its start.
  localparam logic [15:0] REC_BYTES    = 16'h0008;
  localparam logic [15:0] REC_WORD_STEP = 16'h0002;
  localparam logic [7:0]  VEC_OFFSET   = 8'h00;
  localparam logic [1:0]  WORD_CTRL    = 2'h0;
  localparam logic [1:0]  WORD_COUNT   = 2'h1;
  localparam logic [1:0]  WORD_SRC     = 2'h2;
  localparam logic [1:0]  WORD_DST     = 2'h3;

  // Fields of the record control byte.
  localparam int unsigned CTL_MODE       = 0;
  localparam int unsigned CTL_RPT_SIDE   = 1;
  localparam int unsigned CTL_SRC_INC    = 2;
  localparam int unsigned CTL_DST_INC    = 3;
  localparam int unsigned CTL_CHAIN      = 4;
  localparam int unsigned CTL_RPT_IRQ    = 5;
  localparam int unsigned CTL_UNIT_WIDTH = 6;

  // A zero length or count field stands for 256.
  localparam logic [8:0] FULL_256 = 9'h100;

  typedef enum {
    ITDT_IDLE,
    ITDT_VECTOR,
    ITDT_FETCH,
    ITDT_XFER_RD,
    ITDT_XFER_WR,
    ITDT_WRITEBACK
  } itdt_state_e;

  // Request toward the memory bus; held until acknowledged.
  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } itdt_mem_s;

endpackage : itdt_pkg

// [design/itdt_controller.sv]
// Function
// [R1] Twenty-four control records live in RAM.
// [R2] Base page supplies upper address byte.
// [R3] Enabled peripheral interrupts start an activation.
// [R4] Each enable bit maps one fixed source.
// [R5] Read record, transfer, write record back.
// [R6] Normal or repeat mode, byte or word.
// [R7] Chain bit runs following records back to back.
// [R8] Source and destination pointers step independently.
// [R9] Normal mode zero count: interrupt, disable.
// [R10] Repeat with irq enable: interrupt, disable.
// [R11] Chained records never interrupt nor disable; code: only records after the first in a chain stay silent.
// [R12] Normal block: 1-256 units per activation.
// [R13] Normal mode count: 1 to 256 activations.
// [R14] Normal mode pointers step only when enabled.
// [R15] Software zeroes unused reload in normal mode.
// [R16] Repeat block holds at most 255 bytes.
// [R17] Repeat count ranges 1 to 255.
// [R18] Repeat end restores count and repeat pointer.
// [R19] Repeat count refills from reload value.
// [R20] Repeat without irq enable: silent, stays enabled.
// [R21] Base page changes only with sources disabled.
// [R22] Base page written at most once.
// [R23] Transfers never target the base page.
// [R24] Count drops by one; zero means 256.
// [R25] Block length zero means 256 units.
// [R26] Word units force both pointers even.
// [R27] Repeat side select picks repeat pointer.
// [R28] Disabled sources pass straight to controller.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module itdt_controller
  import itdt_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic [itdt_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic      [7:0]                 reg_rdata_o,
  input  wire logic [itdt_pkg::NUM_SRC-1:0] irq_src_i,
  output logic      [itdt_pkg::NUM_SRC-1:0] irq_fwd_o,
  output itdt_pkg::itdt_mem_s             mem_o,
  input  wire logic [15:0]                mem_rdata_i,
  input  wire logic                       mem_ack_i,
  output logic                            busy_o
);
  import itdt_pkg::*;

  typedef struct packed {
    itdt_state_e          st;
    logic [7:0]           base_page;
    logic [NUM_SRC-1:0]   enable;
    logic [NUM_SRC-1:0]   pending;
    logic [NUM_SRC-1:0]   fwd;
    logic [7:0]           rdata;
    itdt_mem_s            mem;
    logic [5:0]           src_idx;
    logic                 first;
    logic [15:0]          rec_addr;
    logic [1:0]           word_idx;
    logic [7:0]           ctl;
    logic [7:0]           blen;
    logic [7:0]           count;
    logic [7:0]           reload;
    logic [15:0]          src_ptr;
    logic [15:0]          dst_ptr;
    logic [8:0]           units_left;
    logic [15:0]          data;
  } itdt_regs_s;

  itdt_regs_s state_reg;
  itdt_regs_s state_next;

  // Lowest numbered pending source wins; the scan also reports whether any is set.
  function automatic logic [6:0] first_set(input logic [NUM_SRC-1:0] vec);
    logic [6:0] res;
    res = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, 6'(i)};
      end
    end
    return res;
  endfunction : first_set

  // Word units ignore address bit 0 so every access is even.
  function automatic logic [15:0] align(input logic [15:0] a, input logic wide);
    return wide ? {a[15:1], 1'b0} : a; // [R26]
  endfunction : align

  // Builds a memory request word in one place.
  function automatic itdt_mem_s mem_cmd(input logic we, input logic wide,
                                        input logic [15:0] addr, input logic [15:0] wdata);
    itdt_mem_s m;
    m.req   = 1'b1;
    m.we    = we;
    m.wide  = wide;
    m.addr  = addr;
    m.wdata = wdata;
    return m;
  endfunction : mem_cmd

  // Zero in an eight-bit length or count field stands for 256.
  function automatic logic [8:0] expand(input logic [7:0] v);
    return (v == 8'h00) ? FULL_256 : {1'b0, v}; // [R24] [R25]
  endfunction : expand

  logic              wide;
  logic              rpt;
  logic [15:0]       step;
  logic [6:0]        pick;
  logic [NUM_SRC-1:0] go_mask;
  logic [NUM_SRC-1:0] src_bit;
  logic [7:0]        cnt_dec;
  logic              end_cnt;
  logic [15:0]       src_adv;
  logic [15:0]       dst_adv;

  assign wide    = state_reg.ctl[CTL_UNIT_WIDTH];                         // [R6]
  assign rpt     = state_reg.ctl[CTL_MODE];                               // [R6]
  assign step    = wide ? 16'h0002 : 16'h0001;
  assign go_mask = state_reg.enable & SRC_VALID_MASK;                     // [R4]
  assign pick    = first_set(state_reg.pending);
  assign src_bit = NUM_SRC'(1) << state_reg.src_idx;
  assign cnt_dec = state_reg.count - 8'h01;                               // [R24]
  assign end_cnt = (cnt_dec == 8'h00);

  // In repeat mode the repeat side always steps; its increment bit has no effect.
  assign src_adv = (rpt ? (state_reg.ctl[CTL_RPT_SIDE] | state_reg.ctl[CTL_SRC_INC])
                        : state_reg.ctl[CTL_SRC_INC])
                 ? state_reg.src_ptr + step : state_reg.src_ptr;          // [R8] [R14] [R27]
  assign dst_adv = (rpt ? (~state_reg.ctl[CTL_RPT_SIDE] | state_reg.ctl[CTL_DST_INC])
                        : state_reg.ctl[CTL_DST_INC])
                 ? state_reg.dst_ptr + step : state_reg.dst_ptr;          // [R8] [R14] [R27]

  // Next-state logic for the register port, source bookkeeping and the transfer engine.
  always_comb begin
    state_next         = state_reg;
    state_next.mem.req = state_reg.mem.req & ~mem_ack_i;
    state_next.rdata   = 8'h00;
    state_next.fwd     = '0;

    // A read answers in the next cycle only; unmapped reads return zero.
    if (reg_re_i) begin
      if (reg_addr_i == BASE_PAGE_ADDR) begin
        state_next.rdata = state_reg.base_page;
      end
      for (int i = 0; i < NUM_SRC / 8; i++) begin
        if (reg_addr_i == ENABLE0_ADDR + REG_AW'(i)) begin
          state_next.rdata = state_reg.enable[8*i +: 8];
        end
      end
    end
    if (reg_we_i) begin
      if (reg_addr_i == BASE_PAGE_ADDR) begin
        state_next.base_page = reg_wdata_i; // [R2]
      end
      for (int i = 0; i < NUM_SRC / 8; i++) begin
        if (reg_addr_i == ENABLE0_ADDR + REG_AW'(i)) begin
          state_next.enable[8*i +: 8] = reg_wdata_i;
        end
      end
    end

    // Engine: every branch except ITDT_IDLE and the default waits for the bus acknowledge before moving on.
    case (state_reg.st)
      ITDT_IDLE: begin
        if (pick[6]) begin
          state_next.src_idx = pick[5:0];
          state_next.pending[pick[5:0]] = 1'b0;
          state_next.first   = 1'b1;
          state_next.mem     = mem_cmd(1'b0, 1'b0,
                                       {state_reg.base_page, VEC_OFFSET + {2'b00, pick[5:0]}},
                                       16'h0000); // [R2]
          state_next.st      = ITDT_VECTOR;
        end
      end
      ITDT_VECTOR: begin
        if (mem_ack_i) begin
          state_next.rec_addr = {state_reg.base_page, mem_rdata_i[7:0]}; // [R1] [R2]
          state_next.word_idx = WORD_CTRL;
          state_next.mem      = mem_cmd(1'b0, 1'b1,
                                        {state_reg.base_page, mem_rdata_i[7:0]}, 16'h0000);
          state_next.st       = ITDT_FETCH;
        end
      end
      ITDT_FETCH: begin
        if (mem_ack_i) begin
          case (state_reg.word_idx)
            WORD_CTRL: begin
              state_next.ctl  = mem_rdata_i[7:0];
              state_next.blen = mem_rdata_i[15:8];
            end
            WORD_COUNT: begin
              state_next.count  = mem_rdata_i[7:0];
              state_next.reload = mem_rdata_i[15:8];
            end
            WORD_SRC: state_next.src_ptr = mem_rdata_i;
            default:  state_next.dst_ptr = mem_rdata_i;
          endcase
          if (state_reg.word_idx == WORD_DST) begin
            state_next.units_left = expand(state_reg.blen);                     // [R12] [R16]
            state_next.mem = mem_cmd(1'b0, state_reg.ctl[CTL_UNIT_WIDTH],
                                     align(state_reg.src_ptr,
                                           state_reg.ctl[CTL_UNIT_WIDTH]), 16'h0000);
            state_next.st  = ITDT_XFER_RD;                                       // [R5]
          end else begin
            state_next.word_idx = state_reg.word_idx + 2'h1;
            state_next.mem = mem_cmd(1'b0, 1'b1,
                                     state_reg.rec_addr
                                     + REC_WORD_STEP * {14'h0000, state_reg.word_idx + 2'h1},
                                     16'h0000);
          end
        end
      end
      ITDT_XFER_RD: begin
        if (mem_ack_i) begin
          state_next.data = wide ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
          state_next.mem  = mem_cmd(1'b1, wide, align(state_reg.dst_ptr, wide),
                                    wide ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]});
          state_next.st   = ITDT_XFER_WR;
        end
      end
      ITDT_XFER_WR: begin
        if (mem_ack_i) begin
          state_next.src_ptr    = src_adv;
          state_next.dst_ptr    = dst_adv;
          state_next.units_left = state_reg.units_left - 9'h001;
          if (state_reg.units_left != 9'h001) begin
            state_next.mem = mem_cmd(1'b0, wide, align(src_adv, wide), 16'h0000);
            state_next.st  = ITDT_XFER_RD;
          end else begin
            // Only the first record of a chain counts; later ones keep their count.
            if (state_reg.first) begin
              state_next.count = cnt_dec; // [R13] [R17] [R24] [R11]
              if (end_cnt && rpt) begin
                state_next.count = state_reg.reload; // [R18] [R19]
                if (state_reg.ctl[CTL_RPT_SIDE]) begin
                  state_next.src_ptr = {src_adv[15:8], 8'h00}; // [R18] [R27]
                end else begin
                  state_next.dst_ptr = {dst_adv[15:8], 8'h00}; // [R18] [R27]
                end
              end
              // Completion: forward the request and clear the enable bit; a request already queued still starts an activation.
              if (end_cnt && (!rpt || state_reg.ctl[CTL_RPT_IRQ])) begin // [R9] [R10] [R20]
                state_next.enable = state_next.enable & ~src_bit; // [R9] [R10]
                state_next.fwd    = src_bit;                      // [R9] [R10]
              end
            end
            state_next.word_idx = WORD_COUNT;
            state_next.mem = mem_cmd(1'b1, 1'b1, state_reg.rec_addr + REC_WORD_STEP,
                                     {state_reg.reload, state_next.count}); // [R5]
            state_next.st  = ITDT_WRITEBACK;
          end
        end
      end
      ITDT_WRITEBACK: begin
        if (mem_ack_i) begin
          if (state_reg.word_idx == WORD_DST) begin
            if (state_reg.ctl[CTL_CHAIN]) begin
              // Next record follows directly after the current one.
              state_next.rec_addr = state_reg.rec_addr + REC_BYTES; // [R7]
              state_next.first    = 1'b0;                           // [R11]
              state_next.word_idx = WORD_CTRL;
              state_next.mem = mem_cmd(1'b0, 1'b1, state_reg.rec_addr + REC_BYTES, 16'h0000);
              state_next.st  = ITDT_FETCH;                          // [R7]
            end else begin
              state_next.st = ITDT_IDLE;
            end
          end else begin
            state_next.word_idx = state_reg.word_idx + 2'h1;
            state_next.mem = mem_cmd(1'b1, 1'b1,
                                     state_reg.rec_addr
                                     + REC_WORD_STEP * {14'h0000, state_reg.word_idx + 2'h1},
                                     (state_reg.word_idx == WORD_COUNT) ? state_reg.src_ptr
                                                                       : state_reg.dst_ptr);
          end
        end
      end
      default: begin
        state_next.st = ITDT_IDLE;
      end
    endcase

    // Enabled requests are queued; a new one wins over the clear of the same bit.
    state_next.pending = state_next.pending | (irq_src_i & go_mask); // [R3] [R4]
    // Sources that may not start a transfer go straight through.
    state_next.fwd = state_next.fwd | (irq_src_i & ~go_mask); // [R28]
  end

  // Single state register; reset puts the engine idle with all sources disabled.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg           <= '0;
      state_reg.st        <= ITDT_IDLE;
      state_reg.base_page <= BASE_PAGE_RESET;
      state_reg.enable    <= {(NUM_SRC / 8){ENABLE_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output except busy_o is a flip-flop of the state register; busy_o decodes the state.
  assign reg_rdata_o = state_reg.rdata;
  assign irq_fwd_o   = state_reg.fwd;
  assign mem_o       = state_reg.mem;
  assign busy_o      = (state_reg.st != ITDT_IDLE);

endmodule : itdt_controller

`default_nettype wire

// [verification/itdt_sva.sv]
`timescale 1ns/100ps
`default_nettype none

module itdt_sva
  import itdt_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         reset_n_i,
  input wire logic [itdt_pkg::REG_AW-1:0]  reg_addr_i,
  input wire logic [7:0]                   reg_wdata_i,
  input wire logic                         reg_we_i,
  input wire logic                         reg_re_i,
  input wire logic [7:0]                   reg_rdata_o,
  input wire logic [itdt_pkg::NUM_SRC-1:0] irq_src_i,
  input wire logic [itdt_pkg::NUM_SRC-1:0] irq_fwd_o,
  input wire itdt_pkg::itdt_mem_s          mem_o,
  input wire logic                         mem_ack_i,
  input wire logic                         busy_o
);
  logic [7:0] base_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Shadow of the base page, so vector fetches can be tied to what software wrote.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      base_reg <= BASE_PAGE_RESET;
    end else if (reg_we_i && reg_addr_i == BASE_PAGE_ADDR) begin
      base_reg <= reg_wdata_i;
    end
  end

  a_rd_idle_zero: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_rd_base_page: assert property (reg_re_i && reg_addr_i == BASE_PAGE_ADDR |=> reg_rdata_o == base_reg)
    else $error("base page read back wrong");
  a_fwd_has_cause: assert property (irq_fwd_o != '0 |-> $past(irq_src_i) != '0 || $past(mem_ack_i))
    else $error("forwarded interrupt without a cause");
  a_rsv_pass: assert property ((irq_src_i & ~SRC_VALID_MASK) != '0 |=>
    (irq_fwd_o & ~SRC_VALID_MASK) == ($past(irq_src_i) & ~SRC_VALID_MASK))
    else $error("reserved source not passed through");
  a_req_held: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
    else $error("memory request changed before its ack");
  a_req_busy: assert property (mem_o.req |-> busy_o)
    else $error("memory request while idle");
  a_word_even: assert property (mem_o.req && mem_o.wide |-> !mem_o.addr[0])
    else $error("word access at odd address");
  a_vec_base: assert property ($rose(busy_o) |-> ##[0:1]
    (mem_o.req && !mem_o.we && !mem_o.wide && mem_o.addr[15:8] == base_reg))
    else $error("activation did not start with a vector read in the base page");

  c_word_write: cover property (mem_o.req && mem_o.we && mem_o.wide && mem_ack_i);
  c_end_irq: cover property ($past(mem_ack_i) && irq_fwd_o != '0);
  c_done: cover property ($fell(busy_o));

endmodule : itdt_sva

bind itdt_controller itdt_sva itdt_sva_inst (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .irq_src_i, .irq_fwd_o, .mem_o, .mem_ack_i, .busy_o);

`default_nettype wire

// [verification/itdt_mem.sv]
`timescale 1ns/100ps
`default_nettype none

module itdt_mem
  import itdt_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire itdt_pkg::itdt_mem_s mem_i,
  input  wire logic                slow_i,
  output logic [15:0]              rdata_o,
  output logic                     ack_o
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_reg;

  // Answers at once or after three waits; between answers the data lines toggle, so
  // stale data never passes for a fresh answer.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      wait_reg <= 2'h0;
      rdata_o <= 16'h0000;
    end else if (mem_i.req && !ack_o && (wait_reg == 2'h3 || !slow_i)) begin
      ack_o <= 1'b1;
      wait_reg <= 2'h0;
      rdata_o <= {mem_i.wide ? mem[mem_i.addr + 16'h1] : ~rdata_o[15:8], mem[mem_i.addr]};
      if (mem_i.we) begin
        mem[mem_i.addr] <= mem_i.wdata[7:0];
      end
      if (mem_i.we && mem_i.wide) begin
        mem[mem_i.addr + 16'h1] <= mem_i.wdata[15:8];
      end
    end else begin
      ack_o <= 1'b0;
      wait_reg <= (mem_i.req && !ack_o) ? wait_reg + 2'h1 : 2'h0;
      rdata_o <= ~rdata_o;
    end
  end

endmodule : itdt_mem

`default_nettype wire

// [verification/test_itdt_controller.sv]
`timescale 1ns/100ps
`default_nettype none

module test_itdt_controller;
  import itdt_pkg::*;

  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [19:0] reg_addr_i = '0;
  logic [7:0]  reg_wdata_i = '0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [39:0] irq_src_i = '0;
  logic [7:0]  reg_rdata_o, v, c, l, n;
  logic [39:0] irq_fwd_o;
  itdt_mem_s   mem_o;
  logic [15:0] mem_rdata_i;
  logic        mem_ack_i, busy_o, slow = 1'b0;
  int          seed = 19130;
  int          n_errors = 0;
  int          n_checks = 0;
  int          nf = 0;
  int          kc = 0;
  int          k;

  itdt_controller itdt_controller_inst (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .irq_src_i, .irq_fwd_o, .mem_o, .mem_rdata_i,
    .mem_ack_i, .busy_o);
  itdt_mem itdt_mem_inst (.clk_i, .reset_n_i, .mem_i(mem_o), .slow_i(slow),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // Clock of 4 ns period.
  always #2 clk_i = ~clk_i;

  // Counts forwarded interrupts of the source under test.
  always @(posedge clk_i) nf <= nf + int'(irq_fwd_o[kc] === 1'b1);

  function automatic logic [7:0] m(input logic [15:0] a);
    return itdt_mem_inst.mem[a];
  endfunction : m

  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge, so they are sampled there.
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : rd

  task automatic pulse(input int k);
    kc = k;
    @(posedge clk_i);
    irq_src_i[k] <= 1'b1;
    @(posedge clk_i);
    irq_src_i[k] <= 1'b0;
  endtask : pulse

  // Bounded wait for the engine to go idle; a hang ends the run as a failure.
  task automatic idle();
    int t;
    t = 0;
    repeat (3) @(posedge clk_i);
    while (busy_o !== 1'b0) begin
      @(posedge clk_i);
      t++;
      if (t > 20000) begin
        n_errors++;
        end_sim();
      end
    end
  endtask : idle

  // A disabled or reserved source must come straight back and start nothing.
  task automatic pass(input int k);
    int f;
    f = nf;
    pulse(k);
    repeat (3) @(posedge clk_i);
    chk(16'(nf - f), 16'h0001);
    chk(16'(busy_o), 16'h0000);
  endtask : pass

  // Software keeps reload at zero in normal mode and aims no transfer at the base page.
  task automatic set(input int k, input logic [7:0] c, l, n, r);
    logic [15:0] a;
    logic [7:0]  b [8];
    a = {8'h80, 8'h30 + 8'(k % 24 * 8)};
    b = '{c, l, n, c[0] ? r : 8'h00, {7'h0, c[6] & ~c[0]}, 8'h10, {7'h0, c[6] & ~c[0]}, 8'h20};
    itdt_mem_inst.mem[16'h8000 + 16'(k)] = a[7:0];
    for (int i = 0; i < 8; i++) itdt_mem_inst.mem[a + 16'(i)] = b[i];
    rd(ENABLE0_ADDR + 20'(k / 8), v);
    wr(ENABLE0_ADDR + 20'(k / 8), v | 8'(1 << (k % 8)));
  endtask : set

  // One activation: predict moved bytes and the written-back record, then compare.
  task automatic fire(input int k);
    logic [15:0] r, s, d, sa, da;
    logic [7:0]  c, cn, ex [int];
    int          n, st, f;
    logic        w, rp, si, di, e;
    r = {8'h80, m(16'h8000 + 16'(k))};
    c = m(r);
    n = (m(r + 16'h1) == 8'h00) ? 256 : int'(m(r + 16'h1));
    cn = m(r + 16'h2) - 8'h01;
    s = {m(r + 16'h5), m(r + 16'h4)};
    d = {m(r + 16'h7), m(r + 16'h6)};
    w = c[6];
    rp = c[0];
    st = w ? 2 : 1;
    si = (rp & c[1]) | c[2];
    di = (rp & ~c[1]) | c[3];
    for (int i = 0; i < n; i++) begin
      sa = (s + 16'(si ? i * st : 0)) & {15'h7fff, ~w};
      da = (d + 16'(di ? i * st : 0)) & {15'h7fff, ~w};
      for (int b = 0; b < st; b++) ex[da + 16'(b)] = m(sa + 16'(b));
    end
    e = (cn == 8'h00) && (!rp || c[5]);
    f = nf;
    slow <= 1'($random(seed));
    pulse(k);
    idle();
    foreach (ex[a]) chk(16'(m(16'(a))), 16'(ex[a]));
    chk(16'(m(r + 16'h2)), 16'((rp && cn == 8'h00) ? m(r + 16'h3) : cn));
    sa = si ? s + 16'(n * st) : s;
    da = di ? d + 16'(n * st) : d;
    if (rp && cn == 8'h00 && c[1]) sa[7:0] = 8'h00;
    if (rp && cn == 8'h00 && !c[1]) da[7:0] = 8'h00;
    chk({m(r + 16'h5), m(r + 16'h4)}, sa);
    chk({m(r + 16'h7), m(r + 16'h6)}, da);
    chk(16'(nf - f), {15'h0, e});
    rd(ENABLE0_ADDR + 20'(k / 8), v);
    chk({15'h0, v[k % 8]}, {15'h0, !e});
  endtask : fire

  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(BASE_PAGE_ADDR, v);
    chk(16'(v), 16'(BASE_PAGE_RESET));
    rd(ENABLE0_ADDR + 20'h4, v);
    chk(16'(v), 16'(ENABLE_RESET));
    rd(20'hf02f0, v);
    chk(16'(v), 16'h0000);
    wr(BASE_PAGE_ADDR, 8'h80);
    rd(BASE_PAGE_ADDR, v);
    chk(16'(v), 16'h0080);
    for (int i = 0; i < 1024; i++) itdt_mem_inst.mem[16'h1000 + 16'(i)] = 8'($random(seed));
    wr(ENABLE0_ADDR, 8'h80);
    pass(7);
    pass(3);
    set(1, 8'h0c, 8'h03, 8'h02, 8'h00);
    repeat (2) fire(1);
    set(9, 8'h48, 8'h00, 8'h01, 8'h00);
    fire(9);
    set(17, 8'h03, 8'h02, 8'h02, 8'h02);
    repeat (3) fire(17);
    set(20, 8'h61, 8'h02, 8'h01, 8'h01);
    fire(20);
    // Chained pair: the second record sits right after the first and keeps its count.
    set(2, 8'h1c, 8'h02, 8'h01, 8'h00);
    for (int i = 0; i < 8; i++) itdt_mem_inst.mem[16'h8048 + 16'(i)] = 8'(64'h2200_1100_0005_010c >> (8 * i));
    l = m(16'h1100);
    fire(2);
    chk(16'(m(16'h2200)), 16'(l));
    chk(16'(m(16'h804a)), 16'h0005);
    chk({m(16'h804d), m(16'h804c)}, 16'h1101);
    set(25, 8'h0c, 8'h01, 8'h00, 8'h00);
    repeat (256) fire(25);
    // Random records; chaining stays off so each record owns its source.
    repeat (8) begin
      k = {$random(seed)} % 40;
      c = 8'($random(seed)) & 8'h6f;
      l = 8'(1 + {$random(seed)} % 4);
      n = 8'(1 + {$random(seed)} % 3);
      if (SRC_VALID_MASK[k]) set(k, c, l, n, n);
      if (SRC_VALID_MASK[k]) repeat (n) fire(k);
    end
    end_sim();
  end

endmodule : test_itdt_controller

`default_nettype wire
